// *** rtl/ep_csr_pkg.sv ***
/*
  Package for the endpoint control and status block: register offsets, field positions,
  reset values, event record and the link answer encoding.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package ep_csr_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] HOST_EP0_CONTROL_STATUS_OFS = 8'h00;
  localparam logic [7:0] PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS = 8'h04;
  localparam logic [7:0] CONFIG_OFS = 8'h08;
  localparam logic [15:0] CSR_RESET = 16'h0000;
  localparam logic [7:0] NAK_LIMIT_RESET = 8'h10;
  localparam logic [1:0] NO_RESPONSE_LIMIT = 2'h3;

  // ************************************************************
  // Host endpoint 0 field positions
  // ************************************************************
  localparam int H_RXRDY = 0;
  localparam int H_TXRDY = 1;
  localparam int H_STALL_RX = 2;
  localparam int H_SETUP = 3;
  localparam int H_ERROR = 4;
  localparam int H_INREQ = 5;
  localparam int H_STATUS = 6;
  localparam int H_NAKTO = 7;
  localparam int H_FLUSH = 8;
  localparam int H_TOG = 9;
  localparam int H_TOGWE = 10;
  localparam int H_SERVRX = 11;

  // ************************************************************
  // Peripheral transmit endpoint field positions
  // ************************************************************
  localparam int P_TXRDY = 0;
  localparam int P_NOTEMPTY = 1;
  localparam int P_UNDERRUN = 2;
  localparam int P_FLUSH = 3;
  localparam int P_SEND_STALL_A = 4;
  localparam int P_STALLSENT = 5;
  localparam int P_CLRTOG = 6;
  localparam int P_DMA_INTERRUPT_MODE = 10;
  localparam int P_FRCTOG = 11;
  localparam int P_DMA_REQUEST_ENABLE = 12;
  localparam int P_DIR = 13;
  localparam int P_ISO = 14;

  // Events reported by the link engine, one-cycle pulses.
  typedef struct packed {
    logic h_tx_done;
    logic h_rx_done;
    logic h_stall;
    logic h_nak;
    logic h_ack;
    logic h_timeout;
    logic p_in_token;
    logic p_tx_done;
    logic p_pkt_loaded;
    logic p_pkt_dropped;
  } link_evt_s;

  // What the host side must send next.
  typedef enum logic [1:0] {
    TOK_NONE,
    TOK_SETUP,
    TOK_OUT,
    TOK_IN
  } token_e;

  // Peripheral answer to an IN token.
  typedef enum logic [1:0] {
    ANS_NONE,
    ANS_DATA,
    ANS_STALL,
    ANS_NAK
  } answer_e;
endpackage : ep_csr_pkg

// *** rtl/usb_endpoint_control_status.sv ***
/*
  Control and status bits for host endpoint 0 and a peripheral transmit endpoint,
  with an APB slave. Assumes a link engine that reports bus events as one-cycle
  pulses on link_evt and obeys the token, answer and flush outputs.
*/
// Design decisions made here: the register addresses and the APB slave port.
// Operation
// - Toggle write enable clears itself after one toggle write.
// - Toggle reads back live; writes take effect only with enable set.
// - Endpoint 0 flush drops a packet, clears ready flags, only if one set.
// - NAK reaching the limit halts endpoint 0 and sets timeout until cleared.
// - Status stage request forces DATA1 for that transaction.
// - In request issues IN; cleared when receive ready sets.
// - Three silent attempts set error and interrupt until cleared.
// - Setup bit with transmit ready selects SETUP token over OUT.
// - Received STALL sets stall received until software clears.
// - Transmit ready clears after sending and raises interrupt if enabled.
// - Received packet sets receive ready with interrupt; service bit clears it.
// - Iso bit selects isochronous, else bulk or interrupt handling.
// - Direction bit sets transmit or receive only for shared FIFO.
// - DMA request asserted only while DMA enable is set.
// - Force toggle switches toggle and drops packet after every send.
// - DMA mode zero interrupts per packet, one with DMA enable set keeps only error and receive interrupts.
// - Clear toggle write resets transmit toggle to zero.
// - Sent STALL sets flag, flushes FIFO, clears transmit ready.
// - Send stall answers IN with STALL unless isochronous.
// - Transmit flush resets pointer, clears ready, only when ready set.
// - IN while transmit ready clear sets underrun until cleared.
// - FIFO not empty flag set while a packet is held.
`timescale 1ns/10ps
module usb_endpoint_control_status
  import ep_csr_pkg::*;
#(
  parameter int NAK_W = 8,
  parameter bit SHARED_FIFO = 1'b1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire link_evt_s link_evt,
  output token_e host_token,
  output logic host_pid_data1,
  output logic host_flush,
  output answer_e peri_answer,
  output logic peri_pid_data1,
  output logic peri_is_iso,
  output logic peri_dir_tx,
  output logic peri_flush,
  output logic dma_req,
  output logic ep_irq
);
  // ************************************************************
  // APB decode
  // ************************************************************
  // Reads complete in the access cycle; the answer is a flop loaded at setup.
  wire setup_ph = psel && !penable && clk_en;
  wire wr_acc = psel && penable && pwrite && pready && clk_en;
  wire sel_h = paddr == HOST_EP0_CONTROL_STATUS_OFS;
  wire sel_p = paddr == PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS;
  wire sel_c = paddr == CONFIG_OFS;
  wire mapped = sel_h || sel_p || sel_c;
  wire wr_h = wr_acc && sel_h;
  wire wr_p = wr_acc && sel_p;
  wire wr_c = wr_acc && sel_c;
  wire [15:0] wd = pwdata[15:0];

  // ************************************************************
  // Host endpoint 0 state
  // ************************************************************
  logic h_rxrdy_q, h_txrdy_q, h_stall_q, h_setup_q, h_err_q, h_inreq_q;
  logic h_status_q, h_nakto_q, h_tog_q;
  logic [NAK_W-1:0] nak_limit_q, nak_cnt_q;
  logic [1:0] try_cnt_q;
  logic p_txrdy_q, p_notempty_q, p_under_q, p_send_stall_a_q, p_stall_sent_q;
  logic p_dma_interrupt_mode_q, p_frctog_q, p_dma_request_enable_q, p_dir_q, p_iso_q, p_tog_q;
  logic [1:0] pkt_cnt_q;

  // Flush only acts while a ready flag stands.
  // flush qualify
  wire h_flush_go = wr_h && wd[H_FLUSH] && (h_txrdy_q || h_rxrdy_q);
  wire p_flush_go = wr_p && wd[P_FLUSH] && p_txrdy_q;
  wire stall_mode = p_send_stall_a_q && !p_iso_q;
  wire stall_sent_ev = link_evt.p_in_token && stall_mode;
  wire under_ev = link_evt.p_in_token && !stall_mode && !p_txrdy_q;
  wire nak_hit = link_evt.h_nak && (nak_cnt_q + NAK_W'(1) >= nak_limit_q);
  wire err_hit = link_evt.h_timeout && (try_cnt_q + 2'd1 == NO_RESPONSE_LIMIT);
  wire p_sent = link_evt.p_tx_done;
  wire p_drop = link_evt.p_pkt_dropped || (p_sent && p_frctog_q);
  wire h_halted = h_nakto_q || h_err_q || h_stall_q;

  // Host ready flags: hardware set wins over software clear.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      h_rxrdy_q <= 1'b0;
      h_txrdy_q <= 1'b0;
      h_inreq_q <= 1'b0;
      h_setup_q <= 1'b0;
      h_status_q <= 1'b0;
    end else if (clk_en) begin
      // receive ready set and service clear
      h_rxrdy_q <= link_evt.h_rx_done || (h_rxrdy_q && !(wr_h && wd[H_SERVRX]) && !h_flush_go);
      h_txrdy_q <= (wr_h && wd[H_TXRDY]) ||
                   (h_txrdy_q && !link_evt.h_tx_done && !h_flush_go && !(wr_h && !wd[H_TXRDY]));
      h_inreq_q <= link_evt.h_rx_done ? 1'b0 : (wr_h ? wd[H_INREQ] : h_inreq_q);
      // setup select held with the write
      h_setup_q <= wr_h ? wd[H_SETUP] : h_setup_q;
      h_status_q <= wr_h ? wd[H_STATUS] : h_status_q;
    end
  end

  // Sticky host error flags: only a written zero clears them.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      h_stall_q <= 1'b0;
      h_err_q <= 1'b0;
      h_nakto_q <= 1'b0;
    end else if (clk_en) begin
      h_stall_q <= link_evt.h_stall || (h_stall_q && !(wr_h && !wd[H_STALL_RX]));
      h_err_q <= err_hit || (h_err_q && !(wr_h && !wd[H_ERROR]));
      h_nakto_q <= nak_hit || (h_nakto_q && !(wr_h && !wd[H_NAKTO]));
    end
  end

  // Host counters for NAKs and silent attempts; ACK or received data restarts both, a NAK restarts the attempt count.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nak_cnt_q <= '0;
      try_cnt_q <= 2'd0;
      nak_limit_q <= NAK_W'(NAK_LIMIT_RESET);
    end else if (clk_en) begin
      if (link_evt.h_ack || link_evt.h_rx_done || nak_hit) begin
        nak_cnt_q <= '0;
      end else if (link_evt.h_nak) begin
        nak_cnt_q <= nak_cnt_q + NAK_W'(1);
      end
      if (link_evt.h_ack || link_evt.h_nak || link_evt.h_rx_done || err_hit) begin
        try_cnt_q <= 2'd0;
      end else if (link_evt.h_timeout) begin
        try_cnt_q <= try_cnt_q + 2'd1;
      end
      if (wr_c) begin
        nak_limit_q <= NAK_W'(pwdata[7:0]);
      end
    end
  end

  // Host toggle: a write lands only when the enable rides in the same write.
  // The enable is never stored, so a later unrelated write cannot disturb the toggle.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      h_tog_q <= 1'b0;
    end else if (clk_en) begin
      // one-shot enable, spent by its own write
      if (wr_h && wd[H_TOGWE]) begin
        h_tog_q <= wd[H_TOG];
      end else if (wr_h && wd[H_STATUS]) begin
        h_tog_q <= 1'b1;
      end else if (link_evt.h_ack || link_evt.h_rx_done) begin
        h_tog_q <= !h_tog_q;
      end
    end
  end

  // ************************************************************
  // Peripheral transmit endpoint state
  // ************************************************************
  // Configuration bits are plain read and write.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      p_dma_interrupt_mode_q <= 1'b0;
      p_frctog_q <= 1'b0;
      p_dma_request_enable_q <= 1'b0;
      p_dir_q <= 1'b0;
      p_iso_q <= 1'b0;
      p_send_stall_a_q <= 1'b0;
    end else if (clk_en && wr_p) begin
      p_dma_interrupt_mode_q <= wd[P_DMA_INTERRUPT_MODE];
      p_frctog_q <= wd[P_FRCTOG];
      p_dma_request_enable_q <= wd[P_DMA_REQUEST_ENABLE];
      p_dir_q <= wd[P_DIR];
      p_iso_q <= wd[P_ISO];
      p_send_stall_a_q <= wd[P_SEND_STALL_A];
    end
  end

  // Peripheral flags and packet count; events win over software, except clear toggle and a transmit ready set in a send cycle.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      p_txrdy_q <= 1'b0;
      p_under_q <= 1'b0;
      p_stall_sent_q <= 1'b0;
      p_tog_q <= 1'b0;
      pkt_cnt_q <= 2'd0;
    end else if (clk_en) begin
      // transmit ready cleared on stall or flush
      p_txrdy_q <= (wr_p && wd[P_TXRDY] && !stall_sent_ev) ||
                   (p_txrdy_q && !p_sent && !stall_sent_ev && !p_flush_go);
      p_under_q <= under_ev || (p_under_q && !(wr_p && !wd[P_UNDERRUN]));
      p_stall_sent_q <= stall_sent_ev || (p_stall_sent_q && !(wr_p && !wd[P_STALLSENT]));
      if (wr_p && wd[P_CLRTOG]) begin
        p_tog_q <= 1'b0;
      end else if (link_evt.p_pkt_dropped || p_drop) begin
        // toggle switches with or without ACK
        p_tog_q <= !p_tog_q;
      end
      // packet count, cleared by stall, decremented by flush or drop
      if (stall_sent_ev) begin
        pkt_cnt_q <= 2'd0;
      end else if (link_evt.p_pkt_loaded && !(p_drop || p_flush_go)) begin
        pkt_cnt_q <= (pkt_cnt_q == 2'd3) ? pkt_cnt_q : pkt_cnt_q + 2'd1;
      end else if (!link_evt.p_pkt_loaded && (p_drop || p_flush_go) && pkt_cnt_q != 2'd0) begin
        pkt_cnt_q <= pkt_cnt_q - 2'd1;
      end
    end
  end

  assign p_notempty_q = pkt_cnt_q != 2'd0;

  // ************************************************************
  // Link side outputs
  // ************************************************************
  token_e tok_d;
  answer_e ans_d;
  assign tok_d = h_halted ? TOK_NONE :
                 h_txrdy_q ? (h_setup_q ? TOK_SETUP : TOK_OUT) :
                 h_inreq_q ? TOK_IN : TOK_NONE;
  assign ans_d = stall_mode ? ANS_STALL : (p_txrdy_q ? ANS_DATA : (p_iso_q ? ANS_NONE : ANS_NAK));
  wire pkt_irq = (p_sent || link_evt.h_tx_done) && !(p_dma_request_enable_q && p_dma_interrupt_mode_q);
  wire err_irq = err_hit || stall_sent_ev || under_ev || nak_hit;
  // direction only counts on a shared FIFO
  wire p_dir_q_eff = SHARED_FIFO ? p_dir_q : 1'b1;
  wire dma_d = p_dma_request_enable_q && p_dir_q_eff && !p_txrdy_q && pkt_cnt_q != 2'd3;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_token <= TOK_NONE;
      host_pid_data1 <= 1'b0;
      host_flush <= 1'b0;
      peri_answer <= ANS_NONE;
      peri_pid_data1 <= 1'b0;
      peri_is_iso <= 1'b0;
      peri_dir_tx <= 1'b1;
      peri_flush <= 1'b0;
      dma_req <= 1'b0;
      ep_irq <= 1'b0;
    end else if (clk_en) begin
      host_token <= tok_d;
      host_pid_data1 <= h_tog_q;
      host_flush <= h_flush_go;
      peri_answer <= ans_d;
      peri_pid_data1 <= p_tog_q;
      peri_is_iso <= p_iso_q;
      peri_dir_tx <= p_dir_q_eff;
      peri_flush <= p_flush_go || stall_sent_ev;
      dma_req <= dma_d;
      ep_irq <= pkt_irq || err_irq || link_evt.h_rx_done;
    end
  end

  // ************************************************************
  // APB read path
  // ************************************************************
  logic [15:0] rd_h, rd_p;
  assign rd_h = {5'h00, 1'b0, h_tog_q, 1'b0, h_nakto_q, h_status_q, h_inreq_q,
                 h_err_q, h_setup_q, h_stall_q, h_txrdy_q, h_rxrdy_q};
  assign rd_p = {1'b0, p_iso_q, p_dir_q, p_dma_request_enable_q, p_frctog_q, p_dma_interrupt_mode_q, 3'h0,
                 1'b0, p_stall_sent_q, p_send_stall_a_q, 1'b0, p_under_q, p_notempty_q, p_txrdy_q};
  wire [31:0] rd_mux = sel_h ? {16'h0000, rd_h} : sel_p ? {16'h0000, rd_p} :
                       sel_c ? {24'h000000, 8'(nak_limit_q)} : 32'h0000_0000;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= setup_ph;
      pslverr <= setup_ph && !mapped;
      prdata <= setup_ph ? rd_mux : prdata;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  togwe_oneshot_a: assert property (clk_en && wr_h && wd[H_TOGWE]
    |=> h_tog_q == $past(wd[H_TOG]))
    else $error("enabled toggle write did not land");
  tog_gate_a: assert property (clk_en && wr_h && !wd[H_TOGWE] && !wd[H_STATUS]
    && !link_evt.h_ack && !link_evt.h_rx_done |=> $stable(h_tog_q))
    else $error("toggle changed without enable");
  flush_idle_a: assert property (clk_en && wr_h && !h_txrdy_q && !h_rxrdy_q |=> !host_flush)
    else $error("flush acted with no ready flag");
  nak_halt_a: assert property (h_nakto_q |-> host_token == TOK_NONE || $rose(h_nakto_q))
    else $error("endpoint 0 not halted after timeout");
  status_data1_a: assert property (clk_en && wr_h && wd[H_STATUS] && !wd[H_TOGWE]
    |=> h_tog_q)
    else $error("status stage not DATA1");
  inreq_clear_a: assert property (clk_en && link_evt.h_rx_done |=> !h_inreq_q && h_rxrdy_q)
    else $error("in request not cleared");
  error_set_a: assert property (clk_en && err_hit |=> h_err_q && ep_irq)
    else $error("error flag missing");
  stall_rx_a: assert property (clk_en && link_evt.h_stall |=> h_stall_q)
    else $error("stall received not set");
  txrdy_done_a: assert property (clk_en && link_evt.h_tx_done && !wr_h |=> !h_txrdy_q)
    else $error("transmit ready stuck");
  dma_gate_a: assert property (dma_req |-> $past(p_dma_request_enable_q))
    else $error("dma request while disabled");
  underrun_a: assert property (clk_en && under_ev |=> p_under_q)
    else $error("underrun not flagged");
  stall_sent_a: assert property (clk_en && stall_sent_ev |=> p_stall_sent_q && !p_txrdy_q)
    else $error("stall sent not handled");
endmodule : usb_endpoint_control_status

// *** verif/link_partner.sv ***
/*
  Link engine stand-in for the endpoint control block: turns event requests from
  the bench into one-cycle pulses on the block's event input.
  Assumes the bench raises each request for exactly one clock cycle.
*/
`timescale 1ns/10ps
module link_partner
  import ep_csr_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire link_evt_s evt_req,
  output link_evt_s link_evt
);
  // ****************************************
  // Event pulses
  // ****************************************
  // Registered so every pulse starts after an edge and lasts as long as its request.
  // events come only after the bench's own register set-up.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_evt <= '0;
    end else begin
      link_evt <= evt_req;
    end
  end
endmodule : link_partner

// *** verif/usb_endpoint_control_status_tb.sv ***
/*
  Self-checking bench for the endpoint control block: APB register tasks, event
  pulses through the link stand-in, and pulse counters on the one-cycle outputs.
  Assumes the map of ep_csr_pkg and an answer two edges after each event.
*/
`timescale 1ns/10ps
module usb_endpoint_control_status_tb
  import ep_csr_pkg::*;
;
  logic core_clk = 0, sys_rst = 1, clk_en = 1;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rv;
  link_evt_s evt_req = '0, link_evt;
  token_e host_token;
  answer_e peri_answer;
  logic host_pid_data1, host_flush, peri_pid_data1, peri_is_iso, peri_dir_tx;
  logic peri_flush, dma_req, ep_irq, ev_err;
  int err_total = 0, checks = 0, n_hf = 0, n_pf = 0, n_irq = 0, n_stl = 0;

  usb_endpoint_control_status dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_evt(link_evt),
    .host_token(host_token), .host_pid_data1(host_pid_data1), .host_flush(host_flush),
    .peri_answer(peri_answer), .peri_pid_data1(peri_pid_data1), .peri_is_iso(peri_is_iso),
    .peri_dir_tx(peri_dir_tx), .peri_flush(peri_flush), .dma_req(dma_req), .ep_irq(ep_irq));
  link_partner far_end (.core_clk(core_clk), .sys_rst(sys_rst), .evt_req(evt_req),
    .link_evt(link_evt));

  // ****************************************
  // Clock and pulse counters
  // ****************************************
  // The one-cycle outputs are counted so no check depends on catching an exact cycle.
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (host_flush === 1'b1) n_hf++;
    if (peri_flush === 1'b1) n_pf++;
    if (ep_irq === 1'b1) n_irq++;
    if (peri_answer === ANS_STALL) n_stl++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic conclude();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'hDEAD, 32'h0);
    rv = prdata;
    ev_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
    repeat (3) @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv & msk, exp);
  endtask : rd

  task automatic ev(input link_evt_s e, input int n);
    repeat (n) begin
      evt_req <= e;
      @(posedge core_clk);
      evt_req <= '0;
      repeat (4) @(posedge core_clk);
    end
  endtask : ev

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    conclude();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    int h, p, q;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(HOST_EP0_CONTROL_STATUS_OFS, 32'hFFFFFFFF, 32'h0);
    rd(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 32'hFFFFFFFF, 32'h0);
    rd(8'h0C, 32'hFFFFFFFF, 32'h0);
    chk(ev_err, 1'b1);
    // Host endpoint 0: toggle write guarding and self-clearing enable.
    wr(HOST_EP0_CONTROL_STATUS_OFS, 16'h0200);
    rd(HOST_EP0_CONTROL_STATUS_OFS, 32'h0600, 32'h0);
    wr(HOST_EP0_CONTROL_STATUS_OFS, 16'h0600);
    rd(HOST_EP0_CONTROL_STATUS_OFS, 32'h0600, 32'h0200);
    chk(host_pid_data1, 1'b1);
    wr(HOST_EP0_CONTROL_STATUS_OFS, 16'h0000);
    rd(HOST_EP0_CONTROL_STATUS_OFS, 32'h0200, 32'h0200);
    // Token choice, transmit completion and IN request.
    wr(HOST_EP0_CONTROL_STATUS_OFS, 16'h000A);
    chk(host_token, TOK_SETUP);
    ev('{h_tx_done: 1'b1, default: 1'b0}, 1);
    rd(HOST_EP0_CONTROL_STATUS_OFS, 32'h0002, 32'h0);
    wr(HOST_EP0_CONTROL_STATUS_OFS, 16'h0002);
    chk(host_token, TOK_OUT);
    wr(HOST_EP0_CONTROL_STATUS_OFS, 16'h0020);
    chk(host_token, TOK_IN);
    q = n_irq;
    ev('{h_rx_done: 1'b1, default: 1'b0}, 1);
    rd(HOST_EP0_CONTROL_STATUS_OFS, 32'h0021, 32'h0001);
    chk(n_irq - q, 1);
    wr(HOST_EP0_CONTROL_STATUS_OFS, 16'h0800);
    rd(HOST_EP0_CONTROL_STATUS_OFS, 32'h0801, 32'h0);
    // Endpoint 0 flush acts only with a ready flag set.
    h = n_hf;
    wr(HOST_EP0_CONTROL_STATUS_OFS, 16'h0100);
    chk(n_hf - h, 0);
    ev('{h_rx_done: 1'b1, default: 1'b0}, 1);
    wr(HOST_EP0_CONTROL_STATUS_OFS, 16'h0100);
    chk(n_hf - h, 1);
    rd(HOST_EP0_CONTROL_STATUS_OFS, 32'h0101, 32'h0);
    // Sticky flags: stall, three silent attempts, NAK limit.
    ev('{h_stall: 1'b1, default: 1'b0}, 1);
    rd(HOST_EP0_CONTROL_STATUS_OFS, 32'h0004, 32'h0004);
    wr(HOST_EP0_CONTROL_STATUS_OFS, 16'h0000);
    rd(HOST_EP0_CONTROL_STATUS_OFS, 32'h0004, 32'h0);
    // Clock enable low: an event in that window must leave no trace.
    clk_en <= 1'b0;
    ev('{h_stall: 1'b1, default: 1'b0}, 1);
    clk_en <= 1'b1;
    rd(HOST_EP0_CONTROL_STATUS_OFS, 32'h0004, 32'h0);
    ev('{h_timeout: 1'b1, default: 1'b0}, 2);
    rd(HOST_EP0_CONTROL_STATUS_OFS, 32'h0010, 32'h0);
    q = n_irq;
    ev('{h_timeout: 1'b1, default: 1'b0}, 1);
    rd(HOST_EP0_CONTROL_STATUS_OFS, 32'h0010, 32'h0010);
    chk(n_irq - q, 1);
    wr(HOST_EP0_CONTROL_STATUS_OFS, 16'h0000);
    wr(CONFIG_OFS, 16'h0002);
    rd(CONFIG_OFS, 32'hFF, 32'h02);
    ev('{h_nak: 1'b1, default: 1'b0}, 1);
    rd(HOST_EP0_CONTROL_STATUS_OFS, 32'h0090, 32'h0);
    ev('{h_nak: 1'b1, default: 1'b0}, 1);
    rd(HOST_EP0_CONTROL_STATUS_OFS, 32'h0080, 32'h0080);
    wr(HOST_EP0_CONTROL_STATUS_OFS, 16'h0000);
    rd(HOST_EP0_CONTROL_STATUS_OFS, 32'h0080, 32'h0);
    // Toggle forced to zero first, so only the status request can make it one.
    wr(HOST_EP0_CONTROL_STATUS_OFS, 16'h0400);
    chk(host_pid_data1, 1'b0);
    wr(HOST_EP0_CONTROL_STATUS_OFS, 16'h0042);
    chk(host_pid_data1, 1'b1);
    wr(HOST_EP0_CONTROL_STATUS_OFS, 16'h0000);
    // Peripheral endpoint: mode bits, DMA gating, stall answers.
    wr(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 16'h6C00);
    rd(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 32'hFFFF, 32'h6C00);
    chk({peri_is_iso, peri_dir_tx, dma_req}, 3'b110);
    // DMA enabled towards transmit: request up, interrupts per packet unless mode is set.
    wr(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 16'h3000);
    chk(dma_req, 1'b1);
    q = n_irq;
    ev('{p_tx_done: 1'b1, default: 1'b0}, 1);
    chk(n_irq - q, 1);
    wr(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 16'h3400);
    q = n_irq;
    ev('{p_tx_done: 1'b1, default: 1'b0}, 1);
    chk(n_irq - q, 0);
    wr(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 16'h0000);
    chk({peri_is_iso, peri_dir_tx}, 2'b00);
    ev('{p_in_token: 1'b1, default: 1'b0}, 1);
    rd(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 32'h0004, 32'h0004);
    wr(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 16'h4010);
    q = n_stl;
    ev('{p_in_token: 1'b1, default: 1'b0}, 1);
    chk(n_stl - q, 0);
    wr(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 16'h0010);
    ev('{p_in_token: 1'b1, default: 1'b0}, 1);
    chk(n_stl > q, 1'b1);
    rd(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 32'h0024, 32'h0020);
    wr(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 16'h0000);
    // FIFO occupancy, forced toggle, clear toggle and transmit flush.
    ev('{p_pkt_loaded: 1'b1, default: 1'b0}, 1);
    rd(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 32'h0002, 32'h0002);
    wr(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 16'h0801);
    ev('{p_tx_done: 1'b1, default: 1'b0}, 1);
    chk(peri_pid_data1, 1'b1);
    wr(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 16'h0040);
    chk(peri_pid_data1, 1'b0);
    rd(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 32'h0048, 32'h0);
    p = n_pf;
    wr(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 16'h0008);
    chk(n_pf - p, 0);
    wr(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 16'h0001);
    wr(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 16'h0008);
    chk(n_pf - p, 1);
    rd(PERIPHERAL_TX_ENDPOINT_CONTROL_STATUS_OFS, 32'h0001, 32'h0);
    // A second reset in mid-run must bring the host and config registers back to their reset values.
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(HOST_EP0_CONTROL_STATUS_OFS, 32'hFFFFFFFF, 32'h0);
    rd(CONFIG_OFS, 32'hFF, {24'h000000, NAK_LIMIT_RESET});
    conclude();
  end
endmodule : usb_endpoint_control_status_tb
